//--- verilog/mepm_monitor.sv
// error pin monitor with axi4-lite registers
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mepm_cfg.svh"
module mepm_monitor
    import mepm_pkg::*;
#(
    parameter int LIM_W  = 8,
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic              ce_i,
    input  wire logic              mcu_fault_input_pin_i,
    input  wire logic [1:0]        dev_state_i,
    input  wire logic              drv_block_i,
    output logic                   drive_enable_output_o,
    output logic                   safe_req_o,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    localparam int TICK_LP  = `MEPM_TICK_LP_US * 1000 / `MEPM_CLK_NS;
    localparam int TICK_PWM = `MEPM_TICK_PWM_US * 1000 / `MEPM_CLK_NS;
    localparam logic [11:0] TICK_LP_M1  = 12'(TICK_LP - 1);
    localparam logic [11:0] TICK_PWM_M1 = 12'(TICK_PWM - 1);

    generate
        if (LIM_W < 2 || LIM_W > 8 || ADDR_W < 4 || TICK_PWM > 4096)
        begin : g_bad_par
            $error("mepm_monitor: unsupported parameter values");
        end
    endgenerate

    mepm_dev_e dev_state;
    assign dev_state = mepm_dev_e'(dev_state_i);

    // ---------------- bus slave ----------------
    logic              aw_rdy_reg;
    logic              w_rdy_reg;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              ar_rdy_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    // handshakes and write decode
    wire aw_hs   = s_axi_awvalid && aw_rdy_reg;
    wire w_hs    = s_axi_wvalid && w_rdy_reg;
    wire b_hs    = bvalid_reg && s_axi_bready;
    wire ar_hs   = s_axi_arvalid && ar_rdy_reg;
    wire r_hs    = rvalid_reg && s_axi_rready;
    wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_b0   = wr_fire && w_strb_reg[0];
    wire in_diag = (dev_state == MEPM_DEV_DIAG);
    wire wa_ctrl = (aw_addr_reg == ADDR_W'(`MEPM_OFS_CTRL));
    wire wa_low  = (aw_addr_reg == ADDR_W'(`MEPM_OFS_LOW_LIM));
    wire wa_high = (aw_addr_reg == ADDR_W'(`MEPM_OFS_HIGH_LIM));
    wire wa_stat = (aw_addr_reg == ADDR_W'(`MEPM_OFS_STAT));
    wire wa_ok   = wa_ctrl || wa_low || wa_high || wa_stat;
    wire wr_ctrl = wr_b0 && wa_ctrl;
    // locked limits answer okay but keep their value
    wire wr_low  = wr_b0 && wa_low && in_diag;
    wire wr_high = wr_b0 && wa_high && in_diag;
    wire clr_wr  = wr_b0 && wa_stat &&
                   !w_data_reg[`MEPM_STAT_FLAG_BIT];

    // write address and data are held until both have arrived
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            aw_rdy_reg  <= 1'b1;
            w_rdy_reg   <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else if (ce_i) begin
            if (aw_hs) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                aw_rdy_reg  <= 1'b0;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end else if (b_hs) begin
                aw_rdy_reg  <= 1'b1;
            end
            if (w_hs) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
                w_rdy_reg  <= 1'b0;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end else if (b_hs) begin
                w_rdy_reg  <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `MEPM_RESP_OKAY;
        end else if (ce_i) begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wa_ok ? `MEPM_RESP_OKAY : `MEPM_RESP_SLVERR;
            end else if (b_hs) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ---------------- registers ----------------
    mepm_ctrl_s       ctrl_reg;
    logic [LIM_W-1:0] low_limit_value_reg;
    logic [LIM_W-1:0] high_limit_value_reg;
    logic             fault_reg;
    logic [3:0]       safe_entry_counter_reg;

    // control and limit registers
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ctrl_reg             <= mepm_ctrl_s'(`MEPM_CTRL_RST);
            low_limit_value_reg  <= LIM_W'(`MEPM_LIM_RST);
            high_limit_value_reg <= LIM_W'(`MEPM_LIM_RST);
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_reg.mode_lp <= w_data_reg[`MEPM_CTRL_MODE_BIT];
                ctrl_reg.mon_dis <= w_data_reg[`MEPM_CTRL_DIS_BIT];
                ctrl_reg.drv_req <= w_data_reg[`MEPM_CTRL_DRV_BIT];
            end
            if (wr_low) begin
                low_limit_value_reg <= w_data_reg[LIM_W-1:0];
            end
            if (wr_high) begin
                high_limit_value_reg <= w_data_reg[LIM_W-1:0];
            end
        end
    end

    // read decode
    logic [31:0] rd_mux;
    logic        ra_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        ra_ok  = 1'b1;
        unique case (s_axi_araddr)
            ADDR_W'(`MEPM_OFS_CTRL):     rd_mux[2:0] = ctrl_reg;
            ADDR_W'(`MEPM_OFS_LOW_LIM):  rd_mux[LIM_W-1:0] =
                                             low_limit_value_reg;
            ADDR_W'(`MEPM_OFS_HIGH_LIM): rd_mux[LIM_W-1:0] =
                                             high_limit_value_reg;
            ADDR_W'(`MEPM_OFS_STAT): begin
                rd_mux[`MEPM_STAT_FLAG_BIT] = fault_reg;
                rd_mux[`MEPM_STAT_CNT_LSB +: 4] = safe_entry_counter_reg;
            end
            default:                     ra_ok = 1'b0;
        endcase
    end

    // read channel, data captured as the address is taken
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ar_rdy_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `MEPM_RESP_OKAY;
        end else if (ce_i) begin
            if (ar_hs) begin
                ar_rdy_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= ra_ok ? `MEPM_RESP_OKAY : `MEPM_RESP_SLVERR;
            end else if (r_hs) begin
                rvalid_reg <= 1'b0;
                ar_rdy_reg <= 1'b1;
            end
        end
    end

    // ---------------- error_signal_monitor ----------------
    logic        pin_prev_reg;
    logic        en_prev_reg;
    logic [11:0] pre_reg;
    logic [LIM_W-1:0] lo_cnt;
    logic [LIM_W-1:0] hi_cnt;
    logic        lo_hit;
    logic        hi_hit;

    // edge and enable detection; the pin is already synchronous
    wire pin      = mcu_fault_input_pin_i;
    wire mon_en   = !ctrl_reg.mon_dis;
    wire pwm_mode = !ctrl_reg.mode_lp;
    wire en_rise  = mon_en && !en_prev_reg;
    wire pin_fall = pin_prev_reg && !pin;
    wire pin_rise = !pin_prev_reg && pin;
    wire pin_edge = pin_fall || pin_rise;
    wire [11:0] tick_m1 = pwm_mode ? TICK_PWM_M1 : TICK_LP_M1;
    wire tick     = (pre_reg == tick_m1);
    wire lo_err   = mon_en && lo_hit;
    wire hi_err   = mon_en && pwm_mode && hi_hit;
    wire err_det  = lo_err || hi_err;
    // a detected error restarts its own counter at zero
    wire lo_clr   = !mon_en || pin_fall || (en_rise && !pin) ||
                    lo_err;
    wire hi_clr   = !mon_en || !pwm_mode || pin_rise ||
                    (en_rise && pin) || hi_err;
    // low counter stops, holding, while the pin is high
    wire lo_inc   = mon_en && !pin && tick;
    wire hi_inc   = mon_en && pwm_mode && pin && tick;

    // tick timer restarts on every edge so ticks align to the partner
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_prev_reg <= `MEPM_PIN_RST;
            en_prev_reg  <= 1'b0;
            pre_reg      <= 12'h000;
        end else if (ce_i) begin
            pin_prev_reg <= pin;
            en_prev_reg  <= mon_en;
            if (!mon_en || pin_edge || en_rise || tick) begin
                pre_reg <= 12'h000;
            end else begin
                pre_reg <= pre_reg + 12'h001;
            end
        end
    end

    mepm_pulse_cnt #(
        .W       (LIM_W)
    ) u_low_cnt (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .clr_i     (lo_clr),
        .inc_i     (lo_inc),
        .limit_i   (low_limit_value_reg),
        .cnt_o     (lo_cnt),
        .hit_o     (lo_hit)
    );

    mepm_pulse_cnt #(
        .W       (LIM_W)
    ) u_high_cnt (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .clr_i     (hi_clr),
        .inc_i     (hi_inc),
        .limit_i   (high_limit_value_reg),
        .cnt_o     (hi_cnt),
        .hit_o     (hi_hit)
    );

    // ---------------- fault flag and safe entry ----------------
    logic safe_arm_reg;
    logic safe_req_reg;
    logic drv_en_reg;

    // set wins over a clear written in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            fault_reg <= 1'b0;
        end else if (ce_i) begin
            if (err_det) begin
                fault_reg <= 1'b1;
            end else if (clr_wr) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // safe request trails the flag by one cycle, only from active
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            safe_arm_reg           <= 1'b0;
            safe_req_reg           <= 1'b0;
            safe_entry_counter_reg <= 4'h0;
        end else if (ce_i) begin
            safe_arm_reg <= err_det && (dev_state == MEPM_DEV_ACTIVE);
            safe_req_reg <= safe_arm_reg;
            if (safe_arm_reg) begin
                safe_entry_counter_reg <= safe_entry_counter_reg + 4'h1;
            end
        end
    end

    // drive enable follows the request unless the flag or drv_block_i blocks it
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            drv_en_reg <= 1'b0;
        end else if (ce_i) begin
            drv_en_reg <= ctrl_reg.drv_req && !fault_reg &&
                          !drv_block_i;
        end
    end

    assign drive_enable_output_o = drv_en_reg;
    assign safe_req_o            = safe_req_reg;
    assign s_axi_awready         = aw_rdy_reg;
    assign s_axi_wready          = w_rdy_reg;
    assign s_axi_bvalid          = bvalid_reg;
    assign s_axi_bresp           = bresp_reg;
    assign s_axi_arready         = ar_rdy_reg;
    assign s_axi_rvalid          = rvalid_reg;
    assign s_axi_rdata           = rdata_reg;
    assign s_axi_rresp           = rresp_reg;

    // ---------------- checks ----------------
    flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ce_i && err_det |=> fault_reg)
        else $error("fault flag not set after detection");

    safe_entry_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && err_det && dev_state == MEPM_DEV_ACTIVE ##1 ce_i
        |=> safe_req_reg)
        else $error("no safe request two cycles after error");

    diag_nosafe_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && dev_state == MEPM_DEV_DIAG && !safe_arm_reg ##1 ce_i
        |=> !safe_req_reg)
        else $error("safe request raised from diagnostic");

    drv_block_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && fault_reg |=> !drive_enable_output_o)
        else $error("drive enable high while flag set");

    entry_count_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && safe_arm_reg
        |=> safe_entry_counter_reg == $past(safe_entry_counter_reg) + 4'h1)
        else $error("safe entry counter did not advance");

    limit_lock_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && wr_b0 && wa_low && !in_diag
        |=> $stable(low_limit_value_reg))
        else $error("low limit changed outside diagnostic");

    fall_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && mon_en && pin_fall |=> lo_cnt == '0)
        else $error("low counter not cleared on falling edge");

    rise_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && mon_en && pin_rise |=> hi_cnt == '0)
        else $error("high counter not cleared on rising edge");

    flag_sticky_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && fault_reg && !clr_wr |=> fault_reg)
        else $error("fault flag dropped without a clear");

    idle_off_a: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ce_i && !mon_en |=> lo_cnt == '0 && hi_cnt == '0)
        else $error("pulse counter running while monitor disabled");

    err_active_c: cover property (@(posedge clk_sys_i)
        disable iff (!rstn_i) safe_req_reg);
    err_diag_c: cover property (@(posedge clk_sys_i)
        disable iff (!rstn_i) err_det && in_diag);
    high_err_c: cover property (@(posedge clk_sys_i)
        disable iff (!rstn_i) hi_err);
    flag_clear_c: cover property (@(posedge clk_sys_i)
        disable iff (!rstn_i) fault_reg ##1 !fault_reg);

endmodule : mepm_monitor

//--- verilog/mepm_cfg.svh
// offsets, field positions, reset values and timing of the pin monitor
`ifndef MEPM_CFG_SVH
`define MEPM_CFG_SVH

// system clock and tick periods
`define MEPM_CLK_NS         5
`define MEPM_TICK_LP_US     5
`define MEPM_TICK_PWM_US    15

// register byte offsets
`define MEPM_OFS_CTRL       8'h00
`define MEPM_OFS_LOW_LIM    8'h04
`define MEPM_OFS_HIGH_LIM   8'h08
`define MEPM_OFS_STAT       8'h0C

// field positions
`define MEPM_CTRL_MODE_BIT  0
`define MEPM_CTRL_DIS_BIT   1
`define MEPM_CTRL_DRV_BIT   2
`define MEPM_STAT_FLAG_BIT  0
`define MEPM_STAT_CNT_LSB   4

// reset values
`define MEPM_CTRL_RST       3'h2
`define MEPM_LIM_RST        8'h01
`define MEPM_PIN_RST        1'b1

// bus answers
`define MEPM_RESP_OKAY      2'h0
`define MEPM_RESP_SLVERR    2'h2

`endif

//--- verilog/mepm_pkg.sv
// types shared by the pin monitor files
package mepm_pkg;

    // device operating state, driven by the device state machine
    typedef enum logic [1:0] {
        MEPM_DEV_INIT   = 2'b00,
        MEPM_DEV_DIAG   = 2'b01,
        MEPM_DEV_ACTIVE = 2'b10,
        MEPM_DEV_SAFE   = 2'b11
    } mepm_dev_e;

    // software control word
    typedef struct packed {
        logic drv_req;
        logic mon_dis;
        logic mode_lp;
    } mepm_ctrl_s;

endpackage : mepm_pkg

//--- verilog/mepm_pulse_cnt.sv
// one pulse-duration counter with limit compare
`timescale 1ns/1ps
module mepm_pulse_cnt
    import mepm_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    input  wire logic         clr_i,
    input  wire logic         inc_i,
    input  wire logic [W-1:0] limit_i,
    output logic      [W-1:0] cnt_o,
    output logic              hit_o
);

    generate
        if (W < 2) begin : g_bad_w
            $error("mepm_pulse_cnt: W must be at least 2");
        end
    endgenerate

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    wire          at_max = &cnt_reg;

    // saturate so a very long phase cannot wrap back below the limit
    assign cnt_next = clr_i ? '0
                    : (inc_i && !at_max) ? cnt_reg + {{(W-1){1'b0}}, 1'b1}
                    : cnt_reg;

    // hit on equality, or at once when a lowered limit is passed;
    // a zero count never hits, so an unsupported zero limit acts as a limit of one
    assign hit_o = (cnt_reg != '0) && (cnt_reg >= limit_i);
    assign cnt_o = cnt_reg;

    // counter register
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : mepm_pulse_cnt

//--- tb/mepm_mcu_model.sv
// behavioural model of the microcontroller driving its error output
`timescale 1ns/1ps
module mepm_mcu_model (
    input  wire logic        clk_sys_i,
    input  wire logic        toggle_i,
    input  wire logic        level_i,
    input  wire logic [15:0] half_cyc_i,
    output logic             pin_o
);
    logic [15:0] cnt_reg;

    // push-pull output, idles high like a healthy part
    initial begin
        pin_o   = 1'b1;
        cnt_reg = 16'h0000;
    end

    // toggles with phases shorter than the limits, or holds a level on
    // command so the bench can stretch a phase into a fault
    always @(posedge clk_sys_i) begin
        if (!toggle_i) begin
            pin_o   <= level_i;
            cnt_reg <= 16'h0000;
        end else if (cnt_reg >= half_cyc_i) begin
            pin_o   <= ~pin_o;
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule : mepm_mcu_model

//--- tb/mepm_monitor_tb.sv
// self-checking bench for the error pin monitor
`timescale 1ns/1ps
`include "mepm_cfg.svh"
module mepm_monitor_tb
    import mepm_pkg::*;
;
    localparam logic [7:0] a_ct = `MEPM_OFS_CTRL;
    localparam logic [7:0] a_lo = `MEPM_OFS_LOW_LIM;
    localparam logic [7:0] a_hi = `MEPM_OFS_HIGH_LIM;
    localparam logic [7:0] a_st = `MEPM_OFS_STAT;

    logic        clk_sys_i, rstn_i, ce_i, drv_block_i, safe_req_o;
    logic        mcu_fault_input_pin_i, drive_enable_output_o;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, toggle, level;
    logic [1:0]  dev_state_i, s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [15:0] half_cyc;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          error_cnt, samples_checked, safe_cnt;

    mepm_monitor i_dut (
        .clk_sys_i, .rstn_i, .ce_i, .mcu_fault_input_pin_i, .dev_state_i,
        .drv_block_i, .drive_enable_output_o, .safe_req_o, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    mepm_mcu_model i_mcu (
        .clk_sys_i, .toggle_i(toggle), .level_i(level),
        .half_cyc_i(half_cyc), .pin_o(mcu_fault_input_pin_i)
    );

    // 200 MHz system clock
    always #2.5 clk_sys_i = ~clk_sys_i;

    // count safe requests seen on the output
    always @(posedge clk_sys_i) begin
        if (rstn_i && safe_req_o === 1'b1) safe_cnt <= safe_cnt + 1;
    end

    task automatic test_done;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic dchk(input string nm, input logic e);
        chk(nm, {31'h0, e}, {31'h0, drive_enable_output_o});
    endtask : dchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    // each channel is dropped at the edge its ready is seen; one idle
    // edge at the end so the next call never reassigns in the same step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done) begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic done;
        done = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done) begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge clk_sys_i);
    endtask : rd

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask : rdc

    // defaults, idle monitor while disabled, unmapped address
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        dchk("drive after reset", 1'b0);
        rdc("ctrl", a_ct, 32'h2);
        rdc("low lim", a_lo, 32'h1);
        rdc("high lim", a_hi, 32'h1);
        level <= 1'b0;
        cyc(4000);
        rdc("stat disabled", a_st, 32'h0);
        rd(8'h10, d, r);
        chk("unmapped resp", {30'h0, `MEPM_RESP_SLVERR}, {30'h0, r});
        level <= 1'b1;
    endtask : t_reset

    // limit writes only take in diagnostic state
    task automatic t_limits;
        dev_state_i <= MEPM_DEV_INIT;
        wr(a_lo, 32'h5);
        rdc("low lim in init", a_lo, 32'h1);
        dev_state_i <= MEPM_DEV_DIAG;
        wr(a_hi, 32'h5);
        rdc("high lim in diag", a_hi, 32'h5);
    endtask : t_limits

    // low-pulse mode; a short low first proves a fall restarts the count
    task automatic t_lowpulse;
        wr(a_lo, 32'h2);
        wr(a_ct, 32'h5);
        cyc(5);
        dchk("drive on", 1'b1);
        ce_i        <= 1'b0;
        drv_block_i <= 1'b1;
        cyc(5);
        dchk("drive frozen", 1'b1);
        ce_i <= 1'b1;
        cyc(5);
        dchk("drive blocked", 1'b0);
        drv_block_i <= 1'b0;
        level <= 1'b0;
        cyc(1500);
        level <= 1'b1;
        cyc(5);
        level <= 1'b0;
        cyc(1900);
        rdc("lp early", a_st, 32'h0);
        cyc(200);
        rdc("lp fault", a_st, 32'h1);
        dchk("drive forced", 1'b0);
        chk("no safe in diag", 32'h0, safe_cnt);
        level <= 1'b1;
        cyc(10);
        rdc("flag sticky", a_st, 32'h1);
        wr(a_st, 32'h0);
        rdc("flag cleared", a_st, 32'h0);
        cyc(3);
        dchk("drive back", 1'b1);
    endtask : t_lowpulse

    // a limit lowered under the running count flags and restarts it
    task automatic t_lower;
        wr(a_lo, 32'hA);
        level <= 1'b0;
        cyc(3500);
        rdc("below limit", a_st, 32'h0);
        wr(a_lo, 32'h2);
        rdc("lowered limit", a_st, 32'h1);
        wr(a_st, 32'h0);
        rdc("count restarted", a_st, 32'h0);
        level <= 1'b1;
    endtask : t_lower

    // pulse-width mode: healthy toggling, then each phase stretched
    task automatic t_pwm;
        wr(a_lo, 32'h2);
        wr(a_hi, 32'h2);
        wr(a_ct, 32'h4);
        wr(a_st, 32'h0);
        toggle <= 1'b1;
        cyc(20000);
        rdc("pwm in limits", a_st, 32'h0);
        toggle <= 1'b0;
        level <= 1'b0;
        cyc(10);
        level <= 1'b1;
        cyc(5800);
        rdc("high phase ok", a_st, 32'h0);
        cyc(400);
        rdc("high too long", a_st, 32'h1);
        level <= 1'b0;
        cyc(5);
        wr(a_st, 32'h0);
        cyc(5700);
        rdc("low phase ok", a_st, 32'h0);
        cyc(400);
        rdc("low too long", a_st, 32'h1);
        level <= 1'b1;
    endtask : t_pwm

    // active state: fault requests safe entry and bumps the counter
    task automatic t_active;
        int n;
        n = 0;
        wr(a_lo, 32'h1);
        wr(a_ct, 32'h5);
        wr(a_st, 32'h0);
        dev_state_i <= MEPM_DEV_ACTIVE;
        level <= 1'b0;
        while (safe_req_o !== 1'b1 && n < 1100) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("safe request", 32'h1, {31'h0, safe_req_o});
        cyc(1);
        dchk("drive at safe", 1'b0);
        dev_state_i <= MEPM_DEV_SAFE;
        cyc(5);
        chk("safe pulses", 32'h1, safe_cnt);
        rdc("stat count", a_st, 32'h11);
    endtask : t_active

    // reset, then the scenarios in turn
    initial begin
        clk_sys_i = 1'b0;
        rstn_i = 1'b0;
        ce_i = 1'b1;
        drv_block_i = 1'b0;
        dev_state_i = MEPM_DEV_DIAG;
        toggle = 1'b0;
        level = 1'b1;
        half_cyc = 16'h07D0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wstrb = 4'hF;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        error_cnt = 0;
        samples_checked = 0;
        safe_cnt = 0;
        cyc(2);
        rstn_i <= 1'b1;
        cyc(1);
        t_reset();
        t_limits();
        t_lowpulse();
        t_lower();
        t_pwm();
        t_active();
        test_done();
    end

    // the run needs about 230 us; a hang is cut at 400 us
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
endmodule : mepm_monitor_tb
